// *** src/tmr_timer8.sv ***
// 8-bit timer/counter with two compare channels behind an axi4-lite slave
`timescale 1ns/1ps
module tmr_timer8
	import tmr_pkg::*;
#(
	parameter int PRESCALE_W = 10
) (
	input wire logic I_CLK_SYS, // 100 mhz system clock
	input wire logic I_NRST, // async reset, active low
	input wire logic [ADDR_W-1:0] I_AWADDR, // write address
	input wire logic I_AWVALID, // write address valid
	output logic O_AWREADY, // write address ready
	input wire logic [31:0] I_WDATA, // write data
	input wire logic [3:0] I_WSTRB, // write strobes
	input wire logic I_WVALID, // write data valid
	output logic O_WREADY, // write data ready
	output logic [1:0] O_BRESP, // write response
	output logic O_BVALID, // write response valid
	input wire logic I_BREADY, // write response ready
	input wire logic [ADDR_W-1:0] I_ARADDR, // read address
	input wire logic I_ARVALID, // read address valid
	output logic O_ARREADY, // read address ready
	output logic [31:0] O_RDATA, // read data
	output logic [1:0] O_RRESP, // read response
	output logic O_RVALID, // read data valid
	input wire logic I_RREADY, // read data ready
	input wire logic I_EXT_COUNT, // external_count_input pin
	input wire logic [2:0] I_IRQ_ACK, // service acknowledge per flag
	output logic [2:0] O_IRQ // interrupt requests {match b, match a, overflow}
);

	// -------------------------------------------------------------------------
	// register state
	// -------------------------------------------------------------------------
	logic [7:0] count_value;
	logic [7:0] compare_a_value;
	logic [7:0] compare_b_value;
	tmr_ctrl_t ctrl;
	tmr_irq_t irq_enable;
	tmr_irq_t flags;
	logic power_off;
	logic global_ie;

	// -------------------------------------------------------------------------
	// axi4-lite write channel
	// -------------------------------------------------------------------------
	logic aw_held, w_held;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_fire;
	logic wr_lane0;
	logic wr_count, wr_flag;

	// address and data may come in either order; both are latched first
	always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
		if (!I_NRST) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
		end else begin
			if (I_AWVALID && O_AWREADY) begin
				aw_held <= 1'b1;
				aw_addr <= I_AWADDR;
			end else if (wr_fire) begin
				aw_held <= 1'b0;
			end
			if (I_WVALID && O_WREADY) begin
				w_held <= 1'b1;
				w_data <= I_WDATA;
				w_strb <= I_WSTRB;
			end else if (wr_fire) begin
				w_held <= 1'b0;
			end
		end
	end

	assign wr_fire = aw_held && w_held && !O_BVALID;
	assign wr_lane0 = wr_fire && w_strb[0];
	assign wr_count = wr_lane0 && aw_addr == ADDR_W'(ADDR_COUNT);
	assign wr_flag = wr_lane0 && aw_addr == ADDR_FLAG;

	// ready registered so outputs come from flip-flops
	always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
		if (!I_NRST) begin
			O_AWREADY <= 1'b0;
			O_WREADY <= 1'b0;
			O_BVALID <= 1'b0;
			O_BRESP <= RESP_OKAY;
		end else begin
			O_AWREADY <= !aw_held && !(I_AWVALID && O_AWREADY);
			O_WREADY <= !w_held && !(I_WVALID && O_WREADY);
			if (wr_fire) begin
				O_BVALID <= 1'b1;
				O_BRESP <= (aw_addr[1:0] == 2'h0 && aw_addr <= ADDR_GLOBAL) ?
					RESP_OKAY : RESP_SLVERR;
			end else if (I_BREADY) begin
				O_BVALID <= 1'b0;
			end
		end
	end

	// configuration registers; power bit resets to off so the timer stays idle
	always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
		if (!I_NRST) begin
			compare_a_value <= COUNT_ZERO;
			compare_b_value <= COUNT_ZERO;
			ctrl <= '0;
			irq_enable <= '0;
			power_off <= POWER_OFF_RESET;
			global_ie <= 1'b0;
		end else if (wr_lane0) begin
			if (aw_addr == ADDR_W'(ADDR_CONTROL)) begin
				ctrl <= w_data[CTRL_MODE_BIT:CTRL_CS_LSB];
			end else if (aw_addr == ADDR_W'(ADDR_COMPARE_A)) begin
				compare_a_value <= w_data[7:0];
			end else if (aw_addr == ADDR_W'(ADDR_COMPARE_B)) begin
				compare_b_value <= w_data[7:0];
			end else if (aw_addr == ADDR_MASK) begin
				irq_enable <= w_data[BIT_MATCH_B:BIT_OVF];
			end else if (aw_addr == ADDR_POWER) begin
				power_off <= w_data[BIT_POWER_OFF];
			end else if (aw_addr == ADDR_GLOBAL) begin
				global_ie <= w_data[BIT_GLOBAL_IE];
			end
		end
	end

	// -------------------------------------------------------------------------
	// axi4-lite read channel
	// -------------------------------------------------------------------------
	logic [31:0] rd_word;

	// read mux; reserved bits and unmapped words read zero
	always_comb begin
		rd_word = '0;
		if (I_ARADDR == ADDR_W'(ADDR_CONTROL)) begin
			rd_word[CTRL_MODE_BIT:CTRL_CS_LSB] = ctrl;
		end else if (I_ARADDR == ADDR_W'(ADDR_COUNT)) begin
			rd_word[7:0] = count_value;
		end else if (I_ARADDR == ADDR_W'(ADDR_COMPARE_A)) begin
			rd_word[7:0] = compare_a_value;
		end else if (I_ARADDR == ADDR_W'(ADDR_COMPARE_B)) begin
			rd_word[7:0] = compare_b_value;
		end else if (I_ARADDR == ADDR_MASK) begin
			rd_word[BIT_MATCH_B:BIT_OVF] = irq_enable;
		end else if (I_ARADDR == ADDR_FLAG) begin
			rd_word[BIT_MATCH_B:BIT_OVF] = flags;
		end else if (I_ARADDR == ADDR_POWER) begin
			rd_word[BIT_POWER_OFF] = power_off;
		end else if (I_ARADDR == ADDR_GLOBAL) begin
			rd_word[BIT_GLOBAL_IE] = global_ie;
		end
	end

	// one read at a time; data registered one cycle after address taken
	always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
		if (!I_NRST) begin
			O_ARREADY <= 1'b0;
			O_RVALID <= 1'b0;
			O_RDATA <= '0;
			O_RRESP <= RESP_OKAY;
		end else begin
			O_ARREADY <= !O_RVALID && !(I_ARVALID && O_ARREADY);
			if (I_ARVALID && O_ARREADY) begin
				O_RVALID <= 1'b1;
				O_RDATA <= rd_word;
				O_RRESP <= (I_ARADDR[1:0] == 2'h0 && I_ARADDR <= ADDR_GLOBAL) ?
					RESP_OKAY : RESP_SLVERR;
			end else if (I_RREADY) begin
				O_RVALID <= 1'b0;
			end
		end
	end

	// -------------------------------------------------------------------------
	// tick generation
	// -------------------------------------------------------------------------
	logic ext_meta, ext_sync, ext_prev;
	logic [PRESCALE_W-1:0] prescale;
	logic timer_tick;
	logic enabled;

	assign enabled = !power_off;

	// two-stage synchroniser then one delay for edge detect
	always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
		if (!I_NRST) begin
			ext_meta <= 1'b0;
			ext_sync <= 1'b0;
			ext_prev <= 1'b0;
		end else begin
			ext_meta <= I_EXT_COUNT;
			ext_sync <= ext_meta;
			ext_prev <= ext_sync;
		end
	end

	// free-running prescaler; halted while powered off to save toggling
	always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
		if (!I_NRST) begin
			prescale <= '0;
		end else if (enabled) begin
			prescale <= prescale + 1'b1;
		end
	end

	// clock select: one-cycle enable, never a derived clock
	always_comb begin
		timer_tick = 1'b0;
		case (ctrl.clock_select_field)
			CS_STOP: timer_tick = 1'b0;
			CS_DIV1: timer_tick = 1'b1;
			CS_DIV8: timer_tick = prescale[$clog2(DIV_8)-1:0] == '1;
			CS_DIV64: timer_tick = prescale[$clog2(DIV_64)-1:0] == '1;
			CS_DIV256: timer_tick = prescale[$clog2(DIV_256)-1:0] == '1;
			CS_DIV1024: timer_tick = prescale[$clog2(DIV_1024)-1:0] == '1;
			CS_PIN_FALL: timer_tick = ext_prev && !ext_sync;
			CS_PIN_RISE: timer_tick = !ext_prev && ext_sync;
			default: timer_tick = 1'b0;
		endcase
		timer_tick = timer_tick && enabled;
	end

	// -------------------------------------------------------------------------
	// counter, compare and flags
	// -------------------------------------------------------------------------
	logic match_a, match_b, block_match;
	logic top_clear, wraps;
	logic [7:0] next_count;
	tmr_irq_t set_flags, clr_flags;

	assign match_a = count_value == compare_a_value;
	assign match_b = count_value == compare_b_value;
	// mode 1 uses compare a as top; mode 0 has top at max
	assign top_clear = ctrl.clear_on_match_select && match_a;
	// a lower compare a simply misses and the counter wraps first
	assign wraps = count_value == COUNT_MAX && !top_clear;
	assign next_count = top_clear ? COUNT_ZERO : count_value + 8'h01;

	// a count write wins over any tick in the same cycle
	always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
		if (!I_NRST) begin
			count_value <= COUNT_ZERO;
		end else if (wr_count) begin
			count_value <= w_data[7:0];
		end else if (timer_tick) begin
			count_value <= next_count;
		end
	end

	// block armed by a count write, consumed by the next tick even when stopped
	always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
		if (!I_NRST) begin
			block_match <= 1'b0;
		end else if (wr_count) begin
			block_match <= 1'b1;
		end else if (timer_tick) begin
			block_match <= 1'b0;
		end
	end

	// hardware sets win over service or software clears
	always_comb begin
		set_flags.overflow = timer_tick && wraps;
		set_flags.match_a = timer_tick && match_a && !block_match;
		set_flags.match_b = timer_tick && match_b && !block_match;
		clr_flags = I_IRQ_ACK;
		if (wr_flag) begin
			clr_flags = clr_flags | w_data[BIT_MATCH_B:BIT_OVF];
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
		if (!I_NRST) begin
			flags <= '0;
		end else begin
			flags <= set_flags | (flags & ~clr_flags);
		end
	end

	// interrupt lines gated by per-source enables and the global enable
	always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
		if (!I_NRST) begin
			O_IRQ <= '0;
		end else begin
			O_IRQ <= global_ie ? (flags & irq_enable & ~clr_flags) : '0;
		end
	end

	// -------------------------------------------------------------------------
	// assertions
	// -------------------------------------------------------------------------
	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_NRST);

	chk_stop_holds: assert property (
		ctrl.clock_select_field == CS_STOP && !wr_count |=> $stable(count_value))
		else $error("counter moved while stopped");
	chk_write_wins: assert property (
		wr_count |=> count_value == $past(w_data[7:0]))
		else $error("count write lost");
	chk_increment: assert property (
		timer_tick && !wr_count && !top_clear |=> count_value == $past(count_value) + 8'h01)
		else $error("tick did not increment");
	chk_ctc_clear: assert property (
		timer_tick && !wr_count && ctrl.clear_on_match_select && match_a
		|=> count_value == COUNT_ZERO)
		else $error("clear on match failed");
	chk_match_flag: assert property (
		timer_tick && match_a && !block_match |=> flags.match_a)
		else $error("match a flag not set");
	chk_block_match: assert property (
		wr_count ##1 (timer_tick && !flags.match_b && !wr_count && !I_IRQ_ACK[BIT_MATCH_B])
		|=> !flags.match_b)
		else $error("match not blocked after count write");
	chk_ovf_set: assert property (
		timer_tick && !wr_count && count_value == COUNT_MAX && !top_clear
		|=> flags.overflow && count_value == COUNT_ZERO)
		else $error("overflow flag missed");
	chk_ovf_sticky: assert property (
		flags.overflow && !clr_flags.overflow |=> flags.overflow)
		else $error("overflow cleared by counting");
	chk_w1c: assert property (
		wr_flag && w_data[BIT_MATCH_A] && !set_flags.match_a |=> !flags.match_a)
		else $error("write one did not clear");
	chk_irq_gate: assert property (
		O_IRQ[BIT_OVF] |-> $past(global_ie && irq_enable.overflow && flags.overflow))
		else $error("overflow irq without enables");
	chk_powered_off: assert property (
		power_off && !wr_count |=> $stable(count_value))
		else $error("counter ran while powered off");
	chk_ovf_only_wrap: assert property (
		!flags.overflow && !(timer_tick && count_value == COUNT_MAX && !top_clear)
		|=> !flags.overflow)
		else $error("overflow set without a wrap");

	// match irq gating, then service and software clears and a zero write that keeps; a set in the same cycle is exempt
	chk_irq_match_a: assert property (
		O_IRQ[BIT_MATCH_A] |-> $past(global_ie && irq_enable.match_a && flags.match_a))
		else $error("match a irq without enables");
	chk_irq_match_b: assert property (
		O_IRQ[BIT_MATCH_B] |-> $past(global_ie && irq_enable.match_b && flags.match_b))
		else $error("match b irq without enables");
	chk_irq_ack: assert property (
		I_IRQ_ACK[BIT_OVF] && !set_flags.overflow |=> !flags.overflow)
		else $error("service did not clear overflow");
	chk_w1c_b: assert property (
		wr_flag && w_data[BIT_MATCH_B] && !set_flags.match_b |=> !flags.match_b)
		else $error("write one did not clear match b");
	chk_w0_keeps: assert property (
		flags.match_a && wr_flag && !w_data[BIT_MATCH_A] && !I_IRQ_ACK[BIT_MATCH_A]
		|=> flags.match_a)
		else $error("write zero cleared a flag");

	// pin path: two stages of delay, and a pin edge makes a single-cycle enable; then read data held until taken
	chk_pin_sync: assert property (
		timer_tick && ctrl.clock_select_field == CS_PIN_RISE
		|-> $past(I_EXT_COUNT, 2) && !$past(I_EXT_COUNT, 3))
		else $error("pin tick not two stages behind the pin");
	chk_pin_single: assert property (
		timer_tick && ctrl.clock_select_field inside {CS_PIN_FALL, CS_PIN_RISE}
		|=> !timer_tick || $changed(ctrl))
		else $error("pin edge gave a tick longer than one cycle");
	chk_rd_hold: assert property (
		O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
		else $error("read data dropped before taken");

	cov_wrap: cover property (timer_tick && wraps);
	cov_ctc: cover property (timer_tick && top_clear);
	cov_ext_tick: cover property (timer_tick && ctrl.clock_select_field == CS_PIN_RISE);
	cov_irq: cover property (O_IRQ[BIT_MATCH_A]);
	cov_blocked: cover property (wr_count ##1 (timer_tick && match_b));

endmodule

// *** src/tmr_pkg.sv ***
// package for the 8-bit timer/counter: register map, fields, timing constants
// -----------------------------------------------------------------------------
// Operation
// - count value and both compare values are 8-bit registers
// - clock select zero stops the counter, no tick produced
// - processor may read and write the count value at any time
// - a count write beats a coincident tick clear or increment
// - each tick increments or clears the counter per mode
// - compare continuously; equality sets the channel flag at the next tick
// - enabled set compare flag requests interrupt; service acknowledge clears it
// - writing one to a flag bit clears it; zero leaves it
// - a count write blocks compare matches on the next tick, even stopped
// - select bit 0 means normal counting, 1 means clear-on-match
// - normal mode counts up only, wraps 0xff to 0x00
// - normal mode sets overflow flag in the tick the counter wraps
// - counting logic only sets overflow; clear by service or write one
// - max is 0xff; top is 0xff or compare a per mode
// - clear-on-match mode clears counter on tick after matching compare a
// - compare a takes effect at once; below count means wrap first
// - clear-on-match mode sets overflow when counter goes max to zero; the code sets none when compare a is 0xff
// - timer stays disabled unless its power-off bit is written zero
// - all logic on system clock; tick is a one-cycle enable
// - tick comes from prescaler or external pin per clock select
// - select codes: stop, /1, /8, /64, /256, /1024, pin fall, pin rise
// - external pin edges count even while pin is an output
// - overflow interrupt needs global enable, overflow enable and flag
// -----------------------------------------------------------------------------
package tmr_pkg;
	// register byte addresses
	localparam logic [3:0] ADDR_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_COUNT = 4'h4;
	localparam logic [3:0] ADDR_COMPARE_A = 4'h8;
	localparam logic [3:0] ADDR_COMPARE_B = 4'hc;
	localparam logic [4:0] ADDR_MASK = 5'h10;
	localparam logic [4:0] ADDR_FLAG = 5'h14;
	localparam logic [4:0] ADDR_POWER = 5'h18;
	localparam logic [4:0] ADDR_GLOBAL = 5'h1c;
	localparam int ADDR_W = 5;
	// field positions
	localparam int CTRL_CS_LSB = 0;
	localparam int CTRL_MODE_BIT = 3;
	localparam int BIT_OVF = 0;
	localparam int BIT_MATCH_A = 1;
	localparam int BIT_MATCH_B = 2;
	localparam int BIT_POWER_OFF = 0;
	localparam int BIT_GLOBAL_IE = 0;
	// values
	localparam logic [7:0] COUNT_MAX = 8'hff;
	localparam logic [7:0] COUNT_ZERO = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic POWER_OFF_RESET = 1'h1;
	localparam int DIV_8 = 8;
	localparam int DIV_64 = 64;
	localparam int DIV_256 = 256;
	localparam int DIV_1024 = 1024;
	// clock select codes
	typedef enum logic [2:0] {
		CS_STOP = 3'b000,
		CS_DIV1 = 3'b001,
		CS_DIV8 = 3'b010,
		CS_DIV64 = 3'b011,
		CS_DIV256 = 3'b100,
		CS_DIV1024 = 3'b101,
		CS_PIN_FALL = 3'b110,
		CS_PIN_RISE = 3'b111
	} tmr_cs_t;
	// control register content
	typedef struct packed {
		logic clear_on_match_select;
		tmr_cs_t clock_select_field;
	} tmr_ctrl_t;
	// interrupt flag / mask triple
	typedef struct packed {
		logic match_b;
		logic match_a;
		logic overflow;
	} tmr_irq_t;
endpackage

// *** verif/tmr_cpu_model.sv ***
// processor-side model: drives the axi4-lite register bus of the timer
`timescale 1ns/1ps
module tmr_cpu_model (
	input wire logic i_clk, // system clock
	output logic [4:0] o_awaddr, // write address
	output logic o_awvalid, // write address valid
	input wire logic i_awready, // write address ready
	output logic [31:0] o_wdata, // write data
	output logic [3:0] o_wstrb, // write strobes
	output logic o_wvalid, // write data valid
	input wire logic i_wready, // write data ready
	input wire logic [1:0] i_bresp, // write response
	input wire logic i_bvalid, // write response valid
	output logic o_bready, // write response ready
	output logic [4:0] o_araddr, // read address
	output logic o_arvalid, // read address valid
	input wire logic i_arready, // read address ready
	input wire logic [31:0] i_rdata, // read data
	input wire logic [1:0] i_rresp, // read response
	input wire logic i_rvalid, // read data valid
	output logic o_rready // read data ready
);
	// ---------------------------------------------------------------
	// idle bus; released payload is inverted so stale data never matches
	// ---------------------------------------------------------------
	initial begin
		o_awaddr = 5'h1f;
		o_awvalid = 1'b0;
		o_wdata = 32'hffffffff;
		o_wstrb = 4'h0;
		o_wvalid = 1'b0;
		o_bready = 1'b0;
		o_araddr = 5'h1f;
		o_arvalid = 1'b0;
		o_rready = 1'b0;
	end
	// one write: address and data offered together, each dropped when taken
	task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge i_clk);
		o_awaddr <= a;
		o_awvalid <= 1'b1;
		o_wdata <= d;
		o_wstrb <= 4'hf;
		o_wvalid <= 1'b1;
		o_bready <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge i_clk);
			if (!aw_done && i_awready === 1'b1) begin
				aw_done = 1'b1;
				o_awvalid <= 1'b0;
				o_awaddr <= ~a;
			end
			if (!w_done && i_wready === 1'b1) begin
				w_done = 1'b1;
				o_wvalid <= 1'b0;
				o_wdata <= ~d;
			end
		end
		do @(posedge i_clk); while (i_bvalid !== 1'b1);
		r = i_bresp;
		o_bready <= 1'b0;
	endtask
	// one read: address held until taken, rready held until rvalid
	task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge i_clk);
		o_araddr <= a;
		o_arvalid <= 1'b1;
		o_rready <= 1'b1;
		do @(posedge i_clk); while (i_arready !== 1'b1);
		o_arvalid <= 1'b0;
		o_araddr <= ~a;
		while (i_rvalid !== 1'b1) @(posedge i_clk);
		d = i_rdata;
		r = i_rresp;
		o_rready <= 1'b0;
	endtask
endmodule

// *** verif/test_timer8_normal_ctc.sv ***
// self-checking testbench for the 8-bit timer/counter
`timescale 1ns/1ps
module test_timer8_normal_ctc;
	import tmr_pkg::*;
	typedef struct {logic [4:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} tmr_row_t;
	logic clk, nrst, ext;
	logic [2:0] ack, irq;
	logic [4:0] awaddr, araddr;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata, rv;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rr;
	int error_cnt = 0;
	int tests_run = 0;
	logic [31:0] rst_val [8] = '{0, 0, 0, 0, 0, 0, 1, 0};
	tmr_row_t rows [9] = '{
		'{ADDR_CONTROL, 32'hff, 32'h0f, RESP_OKAY}, '{ADDR_COUNT, 32'h5a, 32'h5a, RESP_OKAY},
		'{ADDR_COMPARE_A, 32'ha5, 32'ha5, RESP_OKAY}, '{ADDR_COMPARE_B, 32'h3c, 32'h3c, RESP_OKAY},
		'{ADDR_MASK, 32'h07, 32'h07, RESP_OKAY}, '{ADDR_FLAG, 32'h07, 32'h00, RESP_OKAY},
		'{ADDR_MASK, 32'h00, 32'h00, RESP_OKAY}, '{5'h02, 32'h11, 32'h00, RESP_SLVERR},
		'{ADDR_CONTROL, 32'h00, 32'h00, RESP_OKAY}};
	tmr_cs_t pre_cs [3] = '{CS_DIV64, CS_DIV256, CS_DIV1024};
	int pre_div [3] = '{DIV_64, DIV_256, DIV_1024};
	// ---------------------------------------------------------------
	// clock, instances
	// ---------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	tmr_timer8 u_tmr_timer8 (.I_CLK_SYS(clk), .I_NRST(nrst), .I_AWADDR(awaddr),
		.I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(wstrb),
		.I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid),
		.I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
		.O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
		.I_EXT_COUNT(ext), .I_IRQ_ACK(ack), .O_IRQ(irq));
	tmr_cpu_model u_tmr_cpu_model (.i_clk(clk), .o_awaddr(awaddr), .o_awvalid(awvalid),
		.i_awready(awready), .o_wdata(wdata), .o_wstrb(wstrb), .o_wvalid(wvalid),
		.i_wready(wready), .i_bresp(bresp), .i_bvalid(bvalid), .o_bready(bready),
		.o_araddr(araddr), .o_arvalid(arvalid), .i_arready(arready), .i_rdata(rdata),
		.i_rresp(rresp), .i_rvalid(rvalid), .o_rready(rready));
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic w(input logic [4:0] a, input logic [31:0] d);
		u_tmr_cpu_model.wr(a, d, rr);
	endtask
	task automatic rc(input string n, input logic [4:0] a, input logic [31:0] e);
		u_tmr_cpu_model.rd(a, rv, rr);
		chk(n, rv, e);
	endtask
	// one rise and one fall on the pin; long enough for the synchroniser
	task automatic pulse();
		@(posedge clk) ext <= 1'b1;
		repeat (5) @(posedge clk);
		ext <= 1'b0;
		repeat (5) @(posedge clk);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// watchdog: the whole sequence needs under ten thousand cycles
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		conclude();
	end
	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		nrst = 1'b0;
		ext = 1'b0;
		ack = 3'h0;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		for (int i = 0; i < 8; i++) rc("reset value", 5'(i * 4), rst_val[i]);
		$display("test reset done");
		// table rows: write, read back, response code
		foreach (rows[i]) begin
			u_tmr_cpu_model.wr(rows[i].a, rows[i].d, rr);
			chk("write resp", {30'h0, rr}, {30'h0, rows[i].r});
			rc("read back", rows[i].a, rows[i].e);
			chk("read resp", {30'h0, rr}, {30'h0, rows[i].r});
		end
		$display("test rows done");
		// powered off, then stopped: pin edges must not count
		w(ADDR_CONTROL, CS_PIN_RISE);
		pulse();
		rc("count powered off", ADDR_COUNT, 32'h5a);
		w(ADDR_POWER, 32'h0);
		w(ADDR_CONTROL, CS_STOP);
		pulse();
		rc("count stopped", ADDR_COUNT, 32'h5a);
		// normal mode wrap through the pin source
		w(ADDR_CONTROL, CS_PIN_RISE);
		w(ADDR_COUNT, 32'hff);
		pulse();
		rc("count wrap", ADDR_COUNT, 32'h00);
		rc("ovf on wrap", ADDR_FLAG, 32'h01);
		w(ADDR_FLAG, 32'h07);
		// compare a: first tick after the write is blocked anyway
		w(ADDR_COMPARE_A, 32'h02);
		w(ADDR_COUNT, 32'h01);
		pulse();
		pulse();
		rc("count step", ADDR_COUNT, 32'h03);
		rc("match a", ADDR_FLAG, 32'h02);
		w(ADDR_FLAG, 32'h00);
		rc("write zero keeps", ADDR_FLAG, 32'h02);
		w(ADDR_FLAG, 32'h02);
		rc("write one clears", ADDR_FLAG, 32'h00);
		// writing the compare value into the count hides that match
		w(ADDR_COMPARE_B, 32'h10);
		w(ADDR_COUNT, 32'h10);
		pulse();
		rc("blocked match", ADDR_FLAG, 32'h00);
		w(ADDR_COUNT, 32'h0f);
		pulse();
		pulse();
		rc("match b", ADDR_FLAG, 32'h04);
		w(ADDR_FLAG, 32'h07);
		$display("test normal done");
		// clear-on-match: compare a is the top
		w(ADDR_CONTROL, 32'h08 | CS_PIN_RISE);
		w(ADDR_COMPARE_A, 32'h03);
		w(ADDR_COUNT, 32'h02);
		pulse();
		pulse();
		rc("ctc clear", ADDR_COUNT, 32'h00);
		rc("ctc match a", ADDR_FLAG, 32'h02);
		w(ADDR_FLAG, 32'h07);
		// top below the count: runs on to max and wraps
		w(ADDR_COUNT, 32'hfe);
		pulse();
		pulse();
		rc("ctc wrap", ADDR_COUNT, 32'h00);
		rc("ctc ovf", ADDR_FLAG, 32'h01);
		// overflow interrupt needs global enable too
		w(ADDR_MASK, 32'h01);
		repeat (3) @(posedge clk);
		chk("irq no global", {29'h0, irq}, 32'h0);
		w(ADDR_GLOBAL, 32'h01);
		repeat (3) @(posedge clk);
		chk("irq raised", {29'h0, irq}, 32'h1);
		@(posedge clk) ack <= 3'h1;
		@(posedge clk) ack <= 3'h0;
		repeat (3) @(posedge clk);
		chk("irq serviced", {29'h0, irq}, 32'h0);
		rc("flag serviced", ADDR_FLAG, 32'h00);
		$display("test ctc irq done");
		// falling pin edge source
		w(ADDR_CONTROL, CS_PIN_FALL);
		w(ADDR_COUNT, 32'h00);
		pulse();
		rc("fall edge", ADDR_COUNT, 32'h01);
		// prescaled source: about 160 clocks at /8
		w(ADDR_CONTROL, CS_STOP);
		w(ADDR_COUNT, 32'h00);
		w(ADDR_CONTROL, CS_DIV8);
		repeat (160) @(posedge clk);
		w(ADDR_CONTROL, CS_STOP);
		u_tmr_cpu_model.rd(ADDR_COUNT, rv, rr);
		chk("div8 span", 32'(rv >= 19 && rv <= 22), 32'h1);
		// slower dividers: four periods give four or five ticks, phase unknown
		foreach (pre_cs[k]) begin
			w(ADDR_COUNT, 32'h00);
			w(ADDR_CONTROL, pre_cs[k]);
			repeat (4 * pre_div[k]) @(posedge clk);
			w(ADDR_CONTROL, CS_STOP);
			u_tmr_cpu_model.rd(ADDR_COUNT, rv, rr);
			chk("prescaled span", 32'(rv >= 4 && rv <= 5), 32'h1);
		end
		// full rate: a count write equal to compare b hides the very next match
		w(ADDR_FLAG, 32'h07);
		w(ADDR_COMPARE_B, 32'h40);
		w(ADDR_CONTROL, CS_DIV1);
		w(ADDR_COUNT, 32'h40);
		w(ADDR_CONTROL, CS_STOP);
		rc("div1 blocked", ADDR_FLAG, 32'h00);
		u_tmr_cpu_model.rd(ADDR_COUNT, rv, rr);
		chk("div1 span", 32'(rv > 32'h40 && rv < 32'h50), 32'h1);
		$display("test sources done");
		conclude();
	end
endmodule
